// ===== src/rif_regs.svh
// Register map, bit positions and reset values of the interrupt request flags block
`ifndef RIF_REGS_SVH
`define RIF_REGS_SVH

// Register addresses
`define RIF_ADDR_FLAGS0      8'h06
`define RIF_ADDR_FLAGS1      8'h07
`define RIF_ADDR_EN0         8'h08
`define RIF_ADDR_EN1         8'h09

// Set/clear selector carried by a flag register write
`define RIF_SET_BIT          7

// First request group bit positions
`define RIF_F0_HIGH          6
`define RIF_F0_LOW           5
`define RIF_F0_DONE          4
`define RIF_F0_TX            3
`define RIF_F0_RX            2
`define RIF_F0_ERR           1
`define RIF_F0_SOF           0
`define RIF_F0_WIDTH         7

// Second request group bit positions
`define RIF_F1_COMBINED      6
`define RIF_F1_CARD          5
`define RIF_F1_TIMER_TOP     4
`define RIF_F1_WIDTH         6
`define RIF_TIMER_COUNT      5
`define RIF_FAULT_TOP        4

// Enable register bit positions
`define RIF_EN0_INVERT       7
`define RIF_EN1_PUSHPULL     7
`define RIF_EN1_PIN          6

// Reset values
`define RIF_FLAGS0_RESET     7'h00
`define RIF_FLAGS1_RESET     6'h00
`define RIF_EN0_RESET        8'h00
`define RIF_EN1_RESET        8'h00
`define RIF_RDATA_RESET      8'h00
`define RIF_RDATA_UNMAPPED   8'h00

// Command codes: idle code and the set of codes the sequencer accepts
`define RIF_CMD_IDLE         4'h0
`define RIF_CMD_VALID_MASK   16'h00ff

`endif

// ===== src/rif_pkg.sv
// Types shared by the interrupt request flags block
`default_nettype none

package rif_pkg;

    typedef logic [7:0] rif_byte_t;

    typedef logic [3:0] rif_cmd_code_t;

    // One-hot command tracker states
    typedef enum logic [1:0] {
        rif_st_idle = 2'b01,
        rif_st_busy = 2'b10
    } rif_cmd_state_t;

endpackage

`default_nettype wire

// ===== src/rif_cmd_if.sv
// Command start and completion signals between the flag block and its command tracker
`default_nettype none

interface rif_cmd_if;

    logic                   host_write;
    rif_pkg::rif_cmd_code_t host_code;
    logic                   self_end;
    logic                   done_pulse;
    rif_pkg::rif_cmd_code_t field;
    logic                   busy;

    modport tracker (
        input  host_write,
        input  host_code,
        input  self_end,
        output done_pulse,
        output field,
        output busy
    );

    modport owner (
        output host_write,
        output host_code,
        output self_end,
        input  done_pulse,
        input  field,
        input  busy
    );

endinterface

`default_nettype wire

// ===== src/rif_cmd_tracker.sv
// Command field tracker that reports commands returning to idle on their own
`include "rif_regs.svh"
`default_nettype none

module rif_cmd_tracker (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Command signals
    rif_cmd_if.tracker cmd
);
    import rif_pkg::*;

    localparam logic [15:0] valid_mask = `RIF_CMD_VALID_MASK;

    rif_cmd_state_t state_reg;
    rif_cmd_code_t  field_reg;
    logic           done_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= rif_st_idle;
            field_reg <= `RIF_CMD_IDLE;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (cmd.host_write) begin
                // A host start overrides a self end arriving in the same cycle
                if (cmd.host_code == `RIF_CMD_IDLE) begin
                    state_reg <= rif_st_idle;
                    field_reg <= `RIF_CMD_IDLE;
                end else if (!valid_mask[cmd.host_code]) begin
                    state_reg <= rif_st_idle;
                    field_reg <= `RIF_CMD_IDLE;
                    done_reg  <= 1'b1;
                end else begin
                    state_reg <= rif_st_busy;
                    field_reg <= cmd.host_code;
                end
            end else begin
                case (state_reg)
                    rif_st_idle: begin
                        state_reg <= rif_st_idle;
                    end
                    rif_st_busy: begin
                        if (cmd.self_end) begin
                            state_reg <= rif_st_idle;
                            field_reg <= `RIF_CMD_IDLE;
                            done_reg  <= 1'b1;
                        end
                    end
                    default: begin
                        state_reg <= rif_st_idle;
                        field_reg <= `RIF_CMD_IDLE;
                    end
                endcase
            end
        end
    end

    assign cmd.done_pulse = done_reg;
    assign cmd.field      = field_reg;
    assign cmd.busy       = (state_reg == rif_st_busy);

endmodule

`default_nettype wire

// ===== src/rif_top.sv
// Interrupt request flag, enable and pin logic of the reader front end
`include "rif_regs.svh"
`default_nettype none

module rif_top (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst,
    // Register access
    input  wire rif_pkg::rif_byte_t     reg_addr,
    input  wire logic                   reg_wr,
    input  wire rif_pkg::rif_byte_t     reg_wdata,
    input  wire logic                   reg_rd,
    output var  rif_pkg::rif_byte_t     reg_rdata,
    // Command sequencer
    input  wire logic                   cmd_write,
    input  wire rif_pkg::rif_cmd_code_t cmd_code,
    input  wire logic                   cmd_self_end,
    output wire rif_pkg::rif_cmd_code_t cmd_field,
    output wire logic                   cmd_busy,
    // FIFO watermark status
    input  wire logic                   fifo_high_watermark_status,
    input  wire logic                   fifo_low_watermark_status,
    // Transmitter and receiver events
    input  wire logic                   transmit_last_bit,
    input  wire logic                   receive_stream_end,
    input  wire logic                   frame_start_detect,
    input  wire logic                   subcarrier_detect,
    // Error sources
    input  wire logic                   fifo_write_fault,
    input  wire logic                   fifo_overflow_fault,
    input  wire logic                   protocol_fault,
    input  wire logic                   missing_data_fault,
    input  wire logic                   integrity_fault,
    // Card detection and timers
    input  wire logic                   card_detected,
    input  wire logic [4:0]             timer_underflow,
    // Interrupt pin
    output var  logic                   irq_pin_out,
    output var  logic                   irq_pin_oe,
    // Observation
    output wire logic                   combined_request
);
    import rif_pkg::*;

    // Flag and enable state
    logic [`RIF_F0_WIDTH-1:0] flags0_reg;
    logic [`RIF_F0_WIDTH-1:0] flags0_next;
    logic [`RIF_F1_WIDTH-1:0] flags1_reg;
    logic [`RIF_F1_WIDTH-1:0] flags1_next;
    logic                     combined_reg;
    logic                     combined_next;
    rif_byte_t                en0_reg;
    rif_byte_t                en1_reg;
    logic [`RIF_FAULT_TOP:0]  fault_prev_reg;

    // Write decode
    logic                     wr_flags0;
    logic                     wr_flags1;
    logic                     wr_en0;
    logic                     wr_en1;
    logic                     wr_set_mode;
    logic [`RIF_F0_WIDTH-1:0] host_set0;
    logic [`RIF_F0_WIDTH-1:0] host_clr0;
    logic [`RIF_F1_WIDTH-1:0] host_set1;
    logic [`RIF_F1_WIDTH-1:0] host_clr1;

    // Hardware events
    logic [`RIF_F0_WIDTH-1:0] hw_set0;
    logic [`RIF_F1_WIDTH-1:0] hw_set1;
    logic [`RIF_FAULT_TOP:0]  fault_now;
    logic                     fault_rise;

    // Enable fields and pin drive
    logic [`RIF_F0_WIDTH-1:0] gates0;
    logic [`RIF_F1_WIDTH-1:0] gates1;
    logic                     pin_polarity_invert;
    logic                     pin_drive_enable;
    logic                     pin_push_pull;
    logic                     pin_active;
    logic                     pin_level;
    logic                     pin_out_next;
    logic                     pin_oe_next;

    // Read path
    rif_byte_t                rdata_next;

    // Command tracker
    rif_cmd_if cmd_bus ();

    assign cmd_bus.host_write = cmd_write;
    assign cmd_bus.host_code  = cmd_code;
    assign cmd_bus.self_end   = cmd_self_end;
    assign cmd_field          = cmd_bus.field;
    assign cmd_busy           = cmd_bus.busy;

    rif_cmd_tracker u_cmd_tracker (
        .clock (clock),
        .rst   (rst),
        .cmd   (cmd_bus.tracker)
    );

    // Host write decode; the selector only qualifies this one write
    assign wr_flags0   = reg_wr && (reg_addr == `RIF_ADDR_FLAGS0);
    assign wr_flags1   = reg_wr && (reg_addr == `RIF_ADDR_FLAGS1);
    assign wr_en0      = reg_wr && (reg_addr == `RIF_ADDR_EN0);
    assign wr_en1      = reg_wr && (reg_addr == `RIF_ADDR_EN1);
    assign wr_set_mode = reg_wdata[`RIF_SET_BIT];

    assign host_set0 = (wr_flags0 && wr_set_mode)
                     ? reg_wdata[`RIF_F0_WIDTH-1:0]
                     : `RIF_FLAGS0_RESET;
    assign host_clr0 = (wr_flags0 && !wr_set_mode)
                     ? reg_wdata[`RIF_F0_WIDTH-1:0]
                     : `RIF_FLAGS0_RESET;

    // Bit 6 of a second-group write is the combined flag and is ignored
    assign host_set1 = (wr_flags1 && wr_set_mode)
                     ? reg_wdata[`RIF_F1_WIDTH-1:0]
                     : `RIF_FLAGS1_RESET;
    assign host_clr1 = (wr_flags1 && !wr_set_mode)
                     ? reg_wdata[`RIF_F1_WIDTH-1:0]
                     : `RIF_FLAGS1_RESET;

    // Each fault counts when it becomes set, not while it stays set; edges are
    // taken per source so a fault raised under a held one still counts
    assign fault_now  = {fifo_write_fault,
                         fifo_overflow_fault,
                         protocol_fault,
                         missing_data_fault,
                         integrity_fault};
    assign fault_rise = |(fault_now & ~fault_prev_reg);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_prev_reg <= '0;
        end else begin
            fault_prev_reg <= fault_now;
        end
    end

    // Watermark requests are set while the status is high, so a clear
    // during a still-high status does not stick
    assign hw_set0[`RIF_F0_HIGH] = fifo_high_watermark_status;
    assign hw_set0[`RIF_F0_LOW]  = fifo_low_watermark_status;
    assign hw_set0[`RIF_F0_DONE] = cmd_bus.done_pulse;
    assign hw_set0[`RIF_F0_TX]   = transmit_last_bit;
    assign hw_set0[`RIF_F0_RX]   = receive_stream_end;
    assign hw_set0[`RIF_F0_ERR]  = fault_rise;
    assign hw_set0[`RIF_F0_SOF]  = frame_start_detect | subcarrier_detect;

    assign hw_set1[`RIF_F1_CARD]                    = card_detected;
    assign hw_set1[`RIF_F1_TIMER_TOP:0]             = timer_underflow;

    // Per-bit update: a hardware set in the cycle of a host clear wins
    genvar gi;
    generate
        for (gi = 0; gi < `RIF_F0_WIDTH; gi++) begin : g_flags0
            assign flags0_next[gi] = (flags0_reg[gi] && !host_clr0[gi])
                                   || host_set0[gi]
                                   || hw_set0[gi];
        end
        for (gi = 0; gi < `RIF_F1_WIDTH; gi++) begin : g_flags1
            assign flags1_next[gi] = (flags1_reg[gi] && !host_clr1[gi])
                                   || host_set1[gi]
                                   || hw_set1[gi];
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flags0_reg <= `RIF_FLAGS0_RESET;
        end else begin
            flags0_reg <= flags0_next;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flags1_reg <= `RIF_FLAGS1_RESET;
        end else begin
            flags1_reg <= flags1_next;
        end
    end

    // Enable registers are plain read/write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            en0_reg <= `RIF_EN0_RESET;
        end else if (wr_en0) begin
            en0_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            en1_reg <= `RIF_EN1_RESET;
        end else if (wr_en1) begin
            en1_reg <= reg_wdata;
        end
    end

    // Enable register fields
    assign gates0              = en0_reg[`RIF_F0_WIDTH-1:0];
    assign gates1              = en1_reg[`RIF_F1_WIDTH-1:0];
    assign pin_polarity_invert = en0_reg[`RIF_EN0_INVERT];
    assign pin_drive_enable    = en1_reg[`RIF_EN1_PIN];
    assign pin_push_pull       = en1_reg[`RIF_EN1_PUSHPULL];

    // Combined request has no memory of its own: it drops one cycle after the last enabled flag
    assign combined_next = (|(flags0_reg & gates0))
                         | (|(flags1_reg & gates1));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            combined_reg <= 1'b0;
        end else begin
            combined_reg <= combined_next;
        end
    end

    assign combined_request = combined_reg;

    // Pin: push-pull drives both levels, open-drain only pulls low
    assign pin_active = combined_reg && pin_drive_enable;
    assign pin_level  = pin_active ^ pin_polarity_invert;

    // An open-drain pin cannot drive high, so a high level lets go of it and
    // leaves the level to the board's pull-up
    always_comb begin
        pin_out_next = 1'b0;
        pin_oe_next  = !pin_level;
        if (pin_push_pull) begin
            pin_out_next = pin_level;
            pin_oe_next  = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_pin_out <= 1'b0;
            irq_pin_oe  <= 1'b0;
        end else begin
            irq_pin_out <= pin_out_next;
            irq_pin_oe  <= pin_oe_next;
        end
    end

    // Read data: selector bit reads as zero; unmapped addresses read as zero
    always_comb begin
        case (reg_addr)
            `RIF_ADDR_FLAGS0: begin
                rdata_next = {1'b0, flags0_reg};
            end
            `RIF_ADDR_FLAGS1: begin
                rdata_next = {1'b0, combined_reg, flags1_reg};
            end
            `RIF_ADDR_EN0: begin
                rdata_next = en0_reg;
            end
            `RIF_ADDR_EN1: begin
                rdata_next = en1_reg;
            end
            default: begin
                rdata_next = `RIF_RDATA_UNMAPPED;
            end
        endcase
    end

    // Read data is held between reads so a slow host may pick it up late
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= `RIF_RDATA_RESET;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end
    end

endmodule

`default_nettype wire

// ===== verif/rif_host_model.sv
// Host controller model issuing register reads and writes to the flag block
`default_nettype none
module rif_host_model (
    // Clock
    input  wire logic               clock,
    // Register access
    output var  rif_pkg::rif_byte_t reg_addr,
    output var  logic               reg_wr,
    output var  rif_pkg::rif_byte_t reg_wdata,
    output var  logic               reg_rd,
    input  wire rif_pkg::rif_byte_t reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import rif_pkg::*;
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // Idle bus shows the inverse of the last value, so stale data is never sampled quietly
    task automatic wr(input rif_byte_t a, input rif_byte_t d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input rif_byte_t a, output rif_byte_t d);
        @(negedge clock);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clock);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ===== verif/rif_top_properties.sv
// Concurrent checks on the ports of the interrupt request flag block
`include "rif_regs.svh"
`default_nettype none
module rif_top_properties (
    // Clock and reset
    input wire logic                   clock,
    input wire logic                   rst,
    // Register access
    input wire rif_pkg::rif_byte_t     reg_addr,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire rif_pkg::rif_byte_t     reg_rdata,
    // Command sequencer
    input wire logic                   cmd_write,
    input wire rif_pkg::rif_cmd_code_t cmd_code,
    input wire logic                   cmd_self_end,
    input wire rif_pkg::rif_cmd_code_t cmd_field,
    input wire logic                   cmd_busy,
    // Interrupt pin and combined flag
    input wire logic                   irq_pin_out,
    input wire logic                   irq_pin_oe,
    input wire logic                   combined_request
);
    timeunit 1ns;
    timeprecision 1ps;
    import rif_pkg::*;
    localparam logic [15:0] valid_mask = `RIF_CMD_VALID_MASK;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    chk_set_bit_zero: assert property (
        reg_rd && (reg_addr == `RIF_ADDR_FLAGS0 || reg_addr == `RIF_ADDR_FLAGS1)
        |=> !reg_rdata[`RIF_SET_BIT])
        else $error("set selector read back as one");
    // Flags only fall by host writes, and the combined flag lags them by one cycle
    chk_combined_fall: assert property ($fell(combined_request) |-> $past(reg_wr, 2))
        else $error("combined flag fell without a host write");
    chk_pin_cause: assert property (
        $changed(irq_pin_out) |-> $past(combined_request) != $past(combined_request, 2)
        || $past(reg_wr, 2) || $past(reg_wr, 3))
        else $error("pin value moved without a cause");
    chk_released_low: assert property (!irq_pin_oe |-> !irq_pin_out)
        else $error("pin value high while released");
    chk_idle_start: assert property (
        cmd_write && cmd_code == `RIF_CMD_IDLE |=> cmd_field == `RIF_CMD_IDLE && !cmd_busy)
        else $error("idle start left a command running");
    chk_unknown_cmd: assert property (
        cmd_write && !valid_mask[cmd_code]
        |=> !cmd_busy ##1 (!cmd_busy && cmd_field == `RIF_CMD_IDLE))
        else $error("unknown command did not fall back to idle");
    chk_valid_start: assert property (
        cmd_write && valid_mask[cmd_code] && cmd_code != `RIF_CMD_IDLE
        |=> cmd_busy && cmd_field == $past(cmd_code))
        else $error("valid command did not start");
    chk_self_end: assert property (
        cmd_busy && cmd_self_end && !cmd_write |=> !cmd_busy && cmd_field == `RIF_CMD_IDLE)
        else $error("self ending command did not return to idle");

    cover property ($rose(combined_request));
    cover property ($rose(irq_pin_out));
    cover property (cmd_busy && cmd_self_end);
endmodule
`default_nettype wire

// ===== verif/test_reader_interrupt_flags.sv
// Self-checking bench for the interrupt request flag block
`include "rif_regs.svh"
`default_nettype none
module test_reader_interrupt_flags;
    timeunit 1ns;
    timeprecision 1ps;
    import rif_pkg::*;
    typedef struct packed {
        logic [16:0] ev;
        rif_byte_t   f0;
        rif_byte_t   f1;
    } rif_row_t;
    // Event bits: 0 frame start, 1 subcarrier, 2 receive end, 3 transmit end,
    // 8..4 faults, 9 card, 14..10 timers, 15 high and 16 low watermark
    rif_row_t      rows [17] = '{
        '{17'h00001, 8'h01, 8'h00}, '{17'h00002, 8'h01, 8'h00}, '{17'h00004, 8'h04, 8'h00},
        '{17'h00008, 8'h08, 8'h00}, '{17'h00010, 8'h02, 8'h00}, '{17'h00020, 8'h02, 8'h00},
        '{17'h00040, 8'h02, 8'h00}, '{17'h00080, 8'h02, 8'h00}, '{17'h00100, 8'h02, 8'h00},
        '{17'h00200, 8'h00, 8'h20}, '{17'h00400, 8'h00, 8'h01}, '{17'h00800, 8'h00, 8'h02},
        '{17'h01000, 8'h00, 8'h04}, '{17'h02000, 8'h00, 8'h08}, '{17'h04000, 8'h00, 8'h10},
        '{17'h08000, 8'h40, 8'h00}, '{17'h10000, 8'h20, 8'h00}};
    logic          clock        = 1'b0;
    logic          rst          = 1'b1;
    logic          cmd_write    = 1'b0;
    logic          cmd_self_end = 1'b0;
    rif_cmd_code_t cmd_code     = 4'h0;
    logic [16:0]   ev           = 17'h0;
    rif_byte_t     reg_addr, reg_wdata, reg_rdata;
    logic          reg_wr, reg_rd, irq_pin_out, irq_pin_oe, combined_request;
    rif_cmd_code_t cmd_field;
    logic          cmd_busy;
    int            num_errors   = 0;
    int            n_compared   = 0;

    always #20 clock = ~clock;

    rif_top DUT (
        .clock, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .cmd_write, .cmd_code, .cmd_self_end, .cmd_field, .cmd_busy,
        .fifo_high_watermark_status(ev[15]), .fifo_low_watermark_status(ev[16]),
        .transmit_last_bit(ev[3]), .receive_stream_end(ev[2]),
        .frame_start_detect(ev[0]), .subcarrier_detect(ev[1]),
        .fifo_write_fault(ev[4]), .fifo_overflow_fault(ev[5]), .protocol_fault(ev[6]),
        .missing_data_fault(ev[7]), .integrity_fault(ev[8]),
        .card_detected(ev[9]), .timer_underflow(ev[14:10]),
        .irq_pin_out, .irq_pin_oe, .combined_request);

    rif_host_model host (.clock, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);

    task automatic check_byte(input string what, input rif_byte_t exp, input rif_byte_t seen);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic seen);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic expect_reg(input rif_byte_t a, input rif_byte_t exp);
        rif_byte_t d;
        host.rd(a, d);
        check_byte($sformatf("register %h", a), exp, d);
    endtask
    task automatic pulse(input logic [16:0] v);
        @(negedge clock);
        ev = v;
        @(negedge clock);
        ev = 17'h0;
    endtask
    task automatic command(input logic w, input logic e, input rif_cmd_code_t c);
        @(negedge clock);
        cmd_write    = w;
        cmd_self_end = e;
        cmd_code     = c;
        @(negedge clock);
        cmd_write    = 1'b0;
        cmd_self_end = 1'b0;
    endtask
    // Combined flag lags the flags by one edge and the pin by one more
    task automatic wr_settle(input rif_byte_t a, input rif_byte_t d);
        host.wr(a, d);
        repeat (3) @(negedge clock);
    endtask
    task automatic report_and_stop;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge clock);
        rst = 1'b0;
        foreach (rows[i]) begin
            pulse(rows[i].ev);
            expect_reg(`RIF_ADDR_FLAGS0, rows[i].f0);
            expect_reg(`RIF_ADDR_FLAGS1, rows[i].f1);
            host.wr(`RIF_ADDR_FLAGS0, 8'h7f);
            host.wr(`RIF_ADDR_FLAGS1, 8'h3f);
        end
        host.wr(`RIF_ADDR_FLAGS0, 8'hff);
        expect_reg(`RIF_ADDR_FLAGS0, 8'h7f);
        host.wr(`RIF_ADDR_FLAGS0, 8'h12);
        expect_reg(`RIF_ADDR_FLAGS0, 8'h6d);
        host.wr(`RIF_ADDR_FLAGS0, 8'h7f);
        expect_reg(`RIF_ADDR_FLAGS0, 8'h00);
        host.wr(`RIF_ADDR_FLAGS0, 8'h85);
        host.wr(`RIF_ADDR_FLAGS0, 8'h81);
        expect_reg(`RIF_ADDR_FLAGS0, 8'h05);
        host.wr(`RIF_ADDR_FLAGS1, 8'hff);
        expect_reg(`RIF_ADDR_FLAGS1, 8'h3f);
        host.wr(`RIF_ADDR_FLAGS1, 8'h7f);
        expect_reg(`RIF_ADDR_FLAGS1, 8'h00);
        wr_settle(`RIF_ADDR_EN0, 8'h02);
        check_bit("combined", 1'b0, combined_request);
        wr_settle(`RIF_ADDR_EN0, 8'h04);
        check_bit("combined", 1'b1, combined_request);
        check_bit("pin enable", 1'b1, irq_pin_oe);
        expect_reg(`RIF_ADDR_FLAGS1, 8'h40);
        wr_settle(`RIF_ADDR_EN1, 8'h40);
        check_bit("pin enable", 1'b0, irq_pin_oe);
        wr_settle(`RIF_ADDR_EN0, 8'h84);
        check_bit("pin enable", 1'b1, irq_pin_oe);
        expect_reg(`RIF_ADDR_EN0, 8'h84);
        wr_settle(`RIF_ADDR_EN1, 8'hc0);
        check_bit("pin value", 1'b0, irq_pin_out);
        wr_settle(`RIF_ADDR_EN0, 8'h04);
        check_bit("pin value", 1'b1, irq_pin_out);
        host.wr(`RIF_ADDR_FLAGS0, 8'h05);
        wr_settle(`RIF_ADDR_FLAGS1, 8'h81);
        check_bit("combined", 1'b0, combined_request);
        wr_settle(`RIF_ADDR_EN1, 8'hc1);
        check_bit("combined", 1'b1, combined_request);
        wr_settle(`RIF_ADDR_FLAGS1, 8'h01);
        check_bit("pin value", 1'b0, irq_pin_out);
        command(1'b1, 1'b0, 4'h9);
        expect_reg(`RIF_ADDR_FLAGS0, 8'h10);
        check_byte("command field", 8'h00, {4'h0, cmd_field});
        host.wr(`RIF_ADDR_FLAGS0, 8'h10);
        command(1'b1, 1'b0, 4'h3);
        check_bit("command busy", 1'b1, cmd_busy);
        // Idle started over a running command must not look like a self end
        command(1'b1, 1'b0, `RIF_CMD_IDLE);
        expect_reg(`RIF_ADDR_FLAGS0, 8'h00);
        command(1'b1, 1'b0, 4'h3);
        expect_reg(`RIF_ADDR_FLAGS0, 8'h00);
        command(1'b0, 1'b1, 4'h3);
        expect_reg(`RIF_ADDR_FLAGS0, 8'h10);
        check_bit("command busy", 1'b0, cmd_busy);
        // A fault raised while another still holds must raise the error request
        @(negedge clock);
        ev = 17'h00010;
        host.wr(`RIF_ADDR_FLAGS0, 8'h12);
        pulse(17'h00030);
        expect_reg(`RIF_ADDR_FLAGS0, 8'h02);
        host.wr(`RIF_ADDR_FLAGS0, 8'hff);
        @(negedge clock);
        rst = 1'b1;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        for (int a = 6; a < 11; a++) begin
            expect_reg(8'(a), 8'h00);
        end
        check_bit("pin enable", 1'b1, irq_pin_oe);
        report_and_stop();
    end

    // Roughly thirty times the expected run
    initial begin
        #400000;
        num_errors++;
        report_and_stop();
    end
endmodule

bind rif_top rif_top_properties chk (
    .clock, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .cmd_write, .cmd_code,
    .cmd_self_end, .cmd_field, .cmd_busy, .irq_pin_out, .irq_pin_oe, .combined_request);
`default_nettype wire
